/* hw/sdbk_pkg.sv */
/*
 * constants, register map and types of the sd block and descriptor
 * status block. assumes an apb slave with 32-bit data and byte addresses.
 */
// Summary of operation
// - block count 1..65535 decrements per block; zero stops transfer
// - block count used only with counter enable set and multi-block mode
// - ten-bit block size, 1..1023 bytes; zero means no data moves
// - block size and count writes ignored while a transfer runs
// - bit 7 flags a command not issued after stop command error
// - stop command index, end bit, crc, timeout errors at bits 4..1
// - bit 0 set when stop command not executed, clear when executed
// - stop and descriptor error flags read-only, hardware cleared, reset zero
// - descriptor engine flags length mismatch at bit 2
// - error state field: 11 transfer, 01 fetch, 00 stopped, 10 reserved
// - 32-bit writable address of the descriptor entry being executed; fetch done adds 8, so during the transfer it holds the next entry
// - unimplemented bits of these registers read as zero
package sdbk_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_BLKCON  = 8'h00;
    localparam logic [7:0] OFS_STOPSTS = 8'h04;
    localparam logic [7:0] OFS_DMASTS  = 8'h08;
    localparam logic [7:0] OFS_DMAADR  = 8'h0c;
    localparam logic [7:0] OFS_MODE    = 8'h10;
    localparam logic [7:0] OFS_INTSTS  = 8'h14;
    localparam logic [7:0] OFS_INTMSK  = 8'h18;
    localparam logic [7:0] OFS_XFERSTS = 8'h1c;
    // ****************************************
    // fields
    // ****************************************
    localparam int MODE_MULTI  = 0;
    localparam int MODE_BLOCK_COUNTER_ENABLE   = 1;
    localparam int MODE_START  = 8;
    localparam int MODE_STOP   = 9;
    localparam int BLOCKS_TO_TRANSFER_LSB  = 16;
    localparam int STS_NOTISS  = 7;
    localparam int STS_NEXEC   = 0;
    localparam int DMA_LENMIS  = 2;
    localparam int INT_DONE    = 0;
    localparam int INT_STOPERR = 1;
    localparam int INT_DMAERR  = 2;
    localparam int INT_W       = 3;
    // ****************************************
    // reset values and constants
    // ****************************************
    localparam logic [15:0] RST_BLOCKS_TO_TRANSFER = 16'h0000;
    localparam logic [9:0]  RST_TRANSFER_BLOCK_BYTES  = 10'h000;
    localparam logic [31:0] RST_DMAADR = 32'h0000_0000;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        DST_STOP, DST_FETCH, DST_XFER
    } sdbk_dst_t;
    localparam logic [1:0] ERRST_XFER  = 2'b11;
    localparam logic [1:0] ERRST_FETCH = 2'b01;
    localparam logic [1:0] ERRST_STOP  = 2'b00;
endpackage : sdbk_pkg

/* hw/sdbk_edge_sync.sv */
/*
 * two-flop synchroniser for the link clock pin with rising edge pulse.
 * assumes the pin is asynchronous to pclk and much slower than it.
 */
`timescale 1ns/1ps
module sdbk_edge_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      rise
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // ****************************************
    // sync and edge detect
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            rise   <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
            rise   <= sync_r & ~last_r;
        end
    end
endmodule : sdbk_edge_sync

/* hw/sdbk_top.sv */
/*
 * block count and size control, stop command status and descriptor dma
 * status with an apb slave and one level interrupt. assumes the command
 * path and descriptor engine report events as one-cycle pulses on pclk.
 */
`timescale 1ns/1ps
module sdbk_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sd_clk,
    input  wire logic        stop_rsp_vld,
    input  wire logic [3:0]  stop_rsp_err,
    input  wire logic        stop_rsp_nexec,
    input  wire logic        stop_issue_fail,
    input  wire logic        desc_fetch_start,
    input  wire logic        desc_fetch_done,
    input  wire logic        desc_xfer_done,
    input  wire logic        desc_len_mismatch,
    input  wire logic        desc_err,
    output logic             xfer_busy,
    output logic             stop_cmd_req
);
    import sdbk_pkg::*;

    typedef struct packed {
        logic [15:0]        blocks_to_transfer;
        logic [9:0]         transfer_block_bytes;
        logic               multi;
        logic               block_counter_enable;
        logic               busy;
        logic [9:0]         bytes;
        logic [7:0]         stopsts;
        sdbk_dst_t          dst;
        logic [1:0]         errst;
        logic               lenmis;
        logic [31:0]        dmaadr;
        logic [INT_W-1:0]   ists;
        logic [INT_W-1:0]   imsk;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic               irq;
        logic               stop_req;
    } sdbk_st_t;

    sdbk_st_t st_r;
    sdbk_st_t st_nxt;
    logic     link_rise;

    // ****************************************
    // link clock edges
    // ****************************************
    sdbk_edge_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (sd_clk),
        .rise    (link_rise)
    );

    // ****************************************
    // register decode
    // ****************************************
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= OFS_XFERSTS);
    endfunction : mapped

    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input sdbk_st_t s);
        rd_word = 32'h0000_0000;
        case (a)
            OFS_BLKCON:  rd_word = {s.blocks_to_transfer, 6'h00, s.transfer_block_bytes};
            OFS_STOPSTS: rd_word = {24'h00_0000, s.stopsts};
            OFS_DMASTS:  rd_word = {29'h0000_0000, s.lenmis, s.errst};
            OFS_DMAADR:  rd_word = s.dmaadr;
            OFS_MODE:    rd_word = {30'h0000_0000, s.block_counter_enable, s.multi};
            OFS_INTSTS:  rd_word = {29'h0000_0000, s.ists};
            OFS_INTMSK:  rd_word = {29'h0000_0000, s.imsk};
            OFS_XFERSTS: rd_word = {19'h0_0000, s.bytes, s.dst, s.busy};
            default:     rd_word = 32'h0000_0000;
        endcase
    endfunction : rd_word

    function automatic logic [1:0] err_code(input sdbk_dst_t d);
        case (d)
            DST_XFER:  err_code = ERRST_XFER;
            DST_FETCH: err_code = ERRST_FETCH;
            default:   err_code = ERRST_STOP;
        endcase
    endfunction : err_code

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic        wr;
        logic        blk_end;
        logic [15:0] cnt_dec;
        wr      = psel & penable & pwrite & st_r.pready;
        blk_end = 1'b0;
        cnt_dec = st_r.blocks_to_transfer - 16'h0001;
        st_nxt  = st_r;
        st_nxt.pready   = 1'b0;
        st_nxt.pslverr  = 1'b0;
        st_nxt.stop_req = 1'b0;

        // apb setup phase prepares the answer
        if (psel && !penable) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = ~mapped(paddr);
            st_nxt.prdata  = rd_word(paddr, st_r);
        end

        // software writes
        if (wr) begin
            case (paddr)
                OFS_BLKCON: begin
                    if (!st_r.busy) begin
                        st_nxt.blocks_to_transfer = pwdata[BLOCKS_TO_TRANSFER_LSB +: 16];
                        st_nxt.transfer_block_bytes  = pwdata[9:0];
                    end
                end
                OFS_DMAADR: st_nxt.dmaadr = pwdata;
                OFS_MODE: begin
                    if (!st_r.busy) begin
                        st_nxt.multi = pwdata[MODE_MULTI];
                        st_nxt.block_counter_enable  = pwdata[MODE_BLOCK_COUNTER_ENABLE];
                    end
                    if (pwdata[MODE_START] && !st_r.busy &&
                        st_r.transfer_block_bytes != RST_TRANSFER_BLOCK_BYTES &&
                        !(pwdata[MODE_MULTI] && pwdata[MODE_BLOCK_COUNTER_ENABLE] &&
                          st_r.blocks_to_transfer == RST_BLOCKS_TO_TRANSFER)) begin
                        st_nxt.busy    = 1'b1;
                        st_nxt.bytes   = 10'h000;
                        st_nxt.stopsts = 8'h00;
                        st_nxt.errst   = ERRST_STOP;
                        st_nxt.lenmis  = 1'b0;
                    end else if (pwdata[MODE_STOP] && st_r.busy) begin
                        st_nxt.busy     = 1'b0;
                        st_nxt.stop_req = st_r.multi;
                    end
                end
                OFS_INTSTS: st_nxt.ists = st_r.ists & ~pwdata[INT_W-1:0];
                OFS_INTMSK: st_nxt.imsk = pwdata[INT_W-1:0];
                default: ;
            endcase
        end

        // byte and block counting on link edges
        if (st_r.busy && link_rise) begin
            if (st_r.bytes == st_r.transfer_block_bytes - 10'h001) begin
                st_nxt.bytes = 10'h000;
                blk_end      = 1'b1;
            end else begin
                st_nxt.bytes = st_r.bytes + 10'h001;
            end
        end
        if (blk_end) begin
            if (!st_r.multi) begin
                st_nxt.busy = 1'b0;
            end else if (st_r.block_counter_enable) begin
                st_nxt.blocks_to_transfer = cnt_dec;
                if (cnt_dec == 16'h0000) begin
                    st_nxt.busy     = 1'b0;
                    st_nxt.stop_req = 1'b1;
                end
            end
        end
        if (blk_end && st_nxt.busy == 1'b0) begin
            st_nxt.ists[INT_DONE] = 1'b1;
        end

        // stop command results, set after clears
        if (stop_rsp_vld) begin
            st_nxt.stopsts[4:1] = stop_rsp_err;
            st_nxt.stopsts[STS_NEXEC] = stop_rsp_nexec;
            if (stop_rsp_err != 4'h0 || stop_rsp_nexec) begin
                st_nxt.ists[INT_STOPERR] = 1'b1;
            end
        end
        if (stop_issue_fail) begin
            st_nxt.stopsts[STS_NOTISS] = 1'b1;
            st_nxt.ists[INT_STOPERR]   = 1'b1;
        end

        // descriptor engine tracking
        if (desc_err || desc_len_mismatch) begin
            st_nxt.errst = err_code(st_r.dst);
            if (desc_len_mismatch) begin
                st_nxt.lenmis = 1'b1;
            end
            st_nxt.dst = DST_STOP;
            st_nxt.ists[INT_DMAERR] = 1'b1;
        end else if (desc_fetch_done) begin
            st_nxt.dmaadr = st_r.dmaadr + DESC_STRIDE;
            st_nxt.dst    = DST_XFER;
        end else if (desc_fetch_start) begin
            st_nxt.dst = DST_FETCH;
        end else if (desc_xfer_done) begin
            st_nxt.dst = DST_STOP;
        end

        st_nxt.irq = |(st_nxt.ists & st_nxt.imsk);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{blocks_to_transfer: RST_BLOCKS_TO_TRANSFER, transfer_block_bytes: RST_TRANSFER_BLOCK_BYTES,
                      dmaadr: RST_DMAADR, dst: DST_STOP,
                      errst: ERRST_STOP, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata       = st_r.prdata;
    assign pready       = st_r.pready;
    assign pslverr      = st_r.pslverr;
    assign irq          = st_r.irq;
    assign xfer_busy    = st_r.busy;
    assign stop_cmd_req = st_r.stop_req;
endmodule : sdbk_top

/* dv/sdbk_asserts.sv */
/*
 * port checker for sdbk_top: apb timing, read-as-zero fields, start cause.
 * assumes it is bound to every sdbk_top instance.
 */
`timescale 1ns/1ps
module sdbk_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        xfer_busy,
    input wire logic        stop_cmd_req
);
    import sdbk_pkg::*;
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_ack;
    assign rd_ack = pready && !pwrite;
    property p_setup_ready; psel && !penable |=> pready; endproperty
    a_setup_ready: assert property (p_setup_ready)
        else $error("no ready after setup");
    property p_ready_access; pready |-> psel && penable; endproperty
    a_ready_access: assert property (p_ready_access)
        else $error("ready outside access");
    property p_slverr_map;
        pready |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00);
    endproperty
    a_slverr_map: assert property (p_slverr_map)
        else $error("error response mismatch");
    property p_blkcon_zero;
        rd_ack && paddr == OFS_BLKCON |-> prdata[15:10] == 6'h00;
    endproperty
    a_blkcon_zero: assert property (p_blkcon_zero)
        else $error("block control gap not zero");
    property p_stop_zero;
        rd_ack && paddr == OFS_STOPSTS |-> prdata[31:8] == 24'h0
            && prdata[6:5] == 2'b00;
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("stop status gap not zero");
    property p_dma_fields;
        rd_ack && paddr == OFS_DMASTS |-> prdata[31:3] == 29'h0
            && prdata[1:0] != 2'b10;
    endproperty
    a_dma_fields: assert property (p_dma_fields)
        else $error("dma status field bad");
    property p_busy_cause;
        $rose(xfer_busy) |-> $past(psel && penable && pwrite
            && paddr == OFS_MODE && pwdata[MODE_START]);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("transfer began without start");
    property p_req_pulse; stop_cmd_req |-> !xfer_busy ##1 !stop_cmd_req;
    endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("stop request not a pulse");
    c_start: cover property ($rose(xfer_busy));
    c_stop: cover property (stop_cmd_req);
    c_slverr: cover property (pslverr);
endmodule : sdbk_asserts
bind sdbk_top sdbk_asserts sdbk_asserts_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xfer_busy(xfer_busy),
    .stop_cmd_req(stop_cmd_req));

/* dv/sdbk_card_model.sv */
/*
 * card side: link clock while a transfer runs, stop command answer.
 * assumes busy and stop_req come from sdbk_top on pclk.
 */
`timescale 1ns/1ps
module sdbk_card_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       busy,
    input  wire logic       stop_req,
    input  wire logic [3:0] err_sel,
    input  wire logic       nexec_sel,
    output logic            sd_clk,
    output logic            rsp_vld,
    output logic [3:0]      rsp_err,
    output logic            rsp_nexec
);
    logic [1:0] dly_r;
    // clock idles low outside a transfer
    initial begin
        sd_clk = 1'b0;
        #7;
        forever begin
            #100;
            sd_clk = busy ? ~sd_clk : 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_r <= 2'b00;
            rsp_vld <= 1'b0;
        end else begin
            dly_r <= {dly_r[0], stop_req};
            rsp_vld <= dly_r[1];
        end
    end
    // response lines carry junk when not valid
    assign rsp_err = rsp_vld ? err_sel : ~err_sel;
    assign rsp_nexec = rsp_vld ? nexec_sel : ~nexec_sel;
endmodule : sdbk_card_model

/* dv/sdbk_top_tb.sv */
/*
 * bench for sdbk_top: apb register tests, transfers, events.
 * assumes the card model and the bound checker.
 */
`timescale 1ns/1ps
module sdbk_top_tb;
    import sdbk_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        irq, sd_clk, stop_rsp_vld, stop_rsp_nexec, xfer_busy;
    logic [3:0]  stop_rsp_err, err_sel;
    logic        stop_issue_fail, desc_fetch_start, desc_fetch_done;
    logic        desc_xfer_done, desc_len_mismatch, desc_err, nexec_sel;
    logic        stop_cmd_req, e;
    logic [31:0] q;
    int          err_count, comparisons;
    sdbk_top sdbk_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .sd_clk,
        .stop_rsp_vld, .stop_rsp_err, .stop_rsp_nexec, .stop_issue_fail,
        .desc_fetch_start, .desc_fetch_done, .desc_xfer_done,
        .desc_len_mismatch, .desc_err, .xfer_busy, .stop_cmd_req);
    sdbk_card_model sdbk_card_model_inst (.pclk, .presetn,
        .busy(xfer_busy), .stop_req(stop_cmd_req), .err_sel, .nexec_sel,
        .sd_clk, .rsp_vld(stop_rsp_vld), .rsp_err(stop_rsp_err),
        .rsp_nexec(stop_rsp_nexec));
    // ****************************************
    // tasks
    // ****************************************
    task finish_test;
        $display("mismatches %0d compares %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            finish_test();
        end
        @(posedge pclk);
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    task ev(input logic [5:0] v);
        {stop_issue_fail, desc_fetch_start, desc_fetch_done, desc_xfer_done,
            desc_len_mismatch, desc_err} <= v;
        @(posedge pclk);
        {stop_issue_fail, desc_fetch_start, desc_fetch_done, desc_xfer_done,
            desc_len_mismatch, desc_err} <= 6'h00;
        @(posedge pclk);
    endtask : ev
    task idle;
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (xfer_busy !== 1'b0 && n < 4000);
        if (n >= 4000) begin
            err_count++;
            finish_test();
        end
        repeat (8) @(posedge pclk);
    endtask : idle
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, err_sel} = '0;
        {nexec_sel, stop_issue_fail, desc_fetch_start, desc_fetch_done} = '0;
        {desc_xfer_done, desc_len_mismatch, desc_err} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++)
            rd(8'(4 * i), 32'h0);
        $display("reset test done");
        apb(1'b1, OFS_BLKCON, 32'hffff_ffff);
        rd(OFS_BLKCON, 32'hffff_03ff);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, OFS_BLKCON, 32'h0001_0000);
        apb(1'b1, OFS_MODE, 32'h0000_0103);
        chk({31'h0, xfer_busy}, 32'h0);
        $display("register test done");
        for (int i = 0; i < 5; i++) begin
            err_sel <= (i < 4) ? 4'(1 << i) : 4'h0;
            nexec_sel <= (i == 4);
            apb(1'b1, OFS_BLKCON, i == 0 ? 32'h0002_0004 : 32'h0001_0002);
            apb(1'b1, OFS_MODE, 32'h0000_0103);
            if (i == 0)
                apb(1'b1, OFS_BLKCON, 32'h0005_0008);
            idle();
            if (i == 4)
                ev(6'h20);
            rd(OFS_BLKCON, i == 0 ? 32'h4 : 32'h2);
            rd(OFS_STOPSTS, i < 4 ? 32'h2 << i : 32'h81);
        end
        apb(1'b1, OFS_STOPSTS, 32'h0);
        rd(OFS_STOPSTS, 32'h81);
        apb(1'b1, OFS_BLKCON, 32'h0003_0002);
        apb(1'b1, OFS_MODE, 32'h0000_0102);
        idle();
        rd(OFS_BLKCON, 32'h0003_0002);
        // multi-block without counter runs until the stop bit
        apb(1'b1, OFS_MODE, 32'h0000_0101);
        repeat (100) @(posedge pclk);
        chk({31'h0, xfer_busy}, 32'h1);
        apb(1'b1, OFS_MODE, 32'h0000_0200);
        chk({31'h0, xfer_busy}, 32'h0);
        repeat (8) @(posedge pclk);
        rd(OFS_BLKCON, 32'h0003_0002);
        rd(OFS_STOPSTS, 32'h1);
        $display("transfer test done");
        apb(1'b1, OFS_INTMSK, 32'h7);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_INTMSK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_INTMSK, 32'h7);
        apb(1'b1, OFS_INTSTS, 32'h7);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_INTSTS, 32'h0);
        $display("interrupt test done");
        apb(1'b1, OFS_DMAADR, 32'h1000_0000);
        ev(6'h10);
        ev(6'h01);
        rd(OFS_DMASTS, 32'h1);
        apb(1'b1, OFS_DMASTS, 32'h0);
        rd(OFS_DMASTS, 32'h1);
        ev(6'h10);
        ev(6'h08);
        rd(OFS_DMAADR, 32'h1000_0008);
        ev(6'h03);
        rd(OFS_DMASTS, 32'h7);
        ev(6'h09);
        rd(OFS_DMAADR, 32'h1000_0008);
        rd(OFS_DMASTS, 32'h4);
        $display("descriptor test done");
        finish_test();
    end
endmodule : sdbk_top_tb
